/* File: pkg/tsevg_pkg.sv */
// Constants for the timer software event generator.
// Assumes a single 50 MHz clock and a plain register port.
package tsevg_pkg;
  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] EVGEN_OFFSET = 8'h14;
  localparam logic [7:0] CTRL_OFFSET = 8'h00;
  localparam logic [7:0] FLAGS_OFFSET = 8'h10;
  localparam logic [7:0] CAP0_OFFSET = 8'h34;
  localparam logic [7:0] ARVAL_OFFSET = 8'h2c;
  localparam logic [7:0] STATE_OFFSET = 8'h24;
  localparam logic [7:0] PSC_OFFSET = 8'h28;
  // ----------------------------------------------------------------
  // Event register fields
  // ----------------------------------------------------------------
  localparam int UPD_BIT = 0;
  localparam int CH0_BIT = 1;
  localparam int NUM_CHAN = 4;
  // ----------------------------------------------------------------
  // Control register fields
  // ----------------------------------------------------------------
  localparam int DOWN_BIT = 0;
  localparam int CENTER_LO = 1;
  localparam int INPUT_LO = 4;
  localparam int IEN_LO = 8;
  localparam int DEN_LO = 12;
  localparam int CNT_EN_BIT = 16;
  // ----------------------------------------------------------------
  // Flag register fields
  // ----------------------------------------------------------------
  localparam int UPD_FLAG_BIT = 0;
  localparam int CC_FLAG_LO = 1;
  localparam int OVC_FLAG_LO = 9;
  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [31:0] WORD_RST = 32'h0000_0000;
  localparam logic [15:0] ARVAL_RST = 16'hffff;
endpackage

/* File: rtl/tsevg_chan.sv */
// One capture/compare channel: flag, over-capture flag, capture value.
// Assumes the request is a one-cycle pulse from the event register.
`timescale 1ns/10ps
module tsevg_chan #(
  parameter int CW = 16
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic sw_req,
  input wire logic input_mode,
  input wire logic flag_clr,
  input wire logic ovc_clr,
  input wire logic cap_rd,
  input wire logic [CW-1:0] counter,
  output logic capcomp_flag_r,
  output logic overcapture_flag_r,
  output logic [CW-1:0] capture_value_r
);
  // ----------------------------------------------------------------
  // Flags
  // ----------------------------------------------------------------
  // request sets flag
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      capcomp_flag_r <= 1'b0;
    end else if (sw_req) begin
      capcomp_flag_r <= 1'b1;
    end else if (flag_clr || (cap_rd && input_mode)) begin
      capcomp_flag_r <= 1'b0;
    end
  end
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      overcapture_flag_r <= 1'b0;
    end else if (sw_req && input_mode && capcomp_flag_r) begin
      overcapture_flag_r <= 1'b1;
    end else if (ovc_clr) begin
      overcapture_flag_r <= 1'b0;
    end
  end
  // ----------------------------------------------------------------
  // Capture
  // ----------------------------------------------------------------
  // capture counter in input
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      capture_value_r <= '0;
    end else if (sw_req && input_mode) begin
      capture_value_r <= counter;
    end
  end
endmodule

/* File: rtl/tsevg_cnt.sv */
// Counter and prescaler with software update reinitialisation.
// Assumes up/down direction and mode held steady by the register file.
`timescale 1ns/10ps
module tsevg_cnt #(
  parameter int CW = 16
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic enable,
  input wire logic down,
  input wire logic center,
  input wire logic upd_req,
  input wire logic [CW-1:0] psc_val,
  input wire logic [CW-1:0] reload,
  output logic [CW-1:0] count_r,
  output logic [CW-1:0] psc_cnt_r
);
  logic tick;
  assign tick = enable && (psc_cnt_r == psc_val);
  // ----------------------------------------------------------------
  // Prescaler
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      psc_cnt_r <= '0;
    end else if (upd_req || tick) begin
      psc_cnt_r <= '0;
    end else if (enable) begin
      psc_cnt_r <= psc_cnt_r + 1'b1;
    end
  end
  // ----------------------------------------------------------------
  // Counter
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      count_r <= '0;
    end else if (upd_req) begin
      if (center || !down) begin
        count_r <= '0;
      end else begin
        count_r <= reload;
      end
    end else if (tick) begin
      if (down && !center) begin
        count_r <= (count_r == '0) ? reload : count_r - 1'b1;
      end else begin
        count_r <= (count_r >= reload) ? '0 : count_r + 1'b1;
      end
    end
  end
endmodule

/* File: rtl/tsevg_top.sv */
// Software event generator of a general timer, with its registers.
// Assumes a plain register port; read data appear one cycle after the strobe.
//
// Functional notes
// - Channel 0 request self-clears after event
// - Channel 0 request sets flag, irq/dma
// - Input mode request captures counter value
// - Input with flag set sets over-capture
// - Channels 1 to 3 behave alike
// - Update request self-clears after update
// - Update clears counter up/center
// - Update reloads counter when down-counting
// - Update clears prescaler same cycle
`timescale 1ns/10ps
module tsevg_top #(
  parameter int CW = 16
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [31:0] rdata_r,
  output logic [3:0] irq_req_r,
  output logic [3:0] dma_req_r,
  output logic update_irq_r
);
  localparam int N = tsevg_pkg::NUM_CHAN;
  logic [31:0] ctrl_r;
  logic [CW-1:0] reload_r;
  logic [CW-1:0] psc_r;
  logic chan0_event_request;
  logic chan1_event_request;
  logic chan2_event_request;
  logic chan3_event_request;
  logic update_event_request;
  logic [N-1:0] chan_req_r;
  logic update_req_r;
  logic upd_flag_r;
  logic [N-1:0] cc_flag;
  logic [N-1:0] ovc_flag;
  logic [CW-1:0] cap_val [N];
  logic [CW-1:0] count;
  logic [CW-1:0] psc_cnt;
  logic ev_wr;
  logic flags_wr;
  logic [31:0] rdata_nxt;
  // ----------------------------------------------------------------
  // Event register decode
  // ----------------------------------------------------------------
  assign ev_wr = wr_en && (addr == tsevg_pkg::EVGEN_OFFSET);
  assign flags_wr = wr_en && (addr == tsevg_pkg::FLAGS_OFFSET);
  assign update_event_request = ev_wr && wdata[tsevg_pkg::UPD_BIT];
  assign chan0_event_request = ev_wr && wdata[tsevg_pkg::CH0_BIT];
  assign chan1_event_request = ev_wr && wdata[tsevg_pkg::CH0_BIT + 1];
  assign chan2_event_request = ev_wr && wdata[tsevg_pkg::CH0_BIT + 2];
  assign chan3_event_request = ev_wr && wdata[tsevg_pkg::CH0_BIT + 3];
  // Request bits held for the cycle in which the event is generated
  // set by one, cleared after
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      chan_req_r <= '0;
      update_req_r <= 1'b0;
    end else begin
      chan_req_r <= {chan3_event_request, chan2_event_request,
                     chan1_event_request, chan0_event_request};
      update_req_r <= update_event_request;
    end
  end
  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      ctrl_r <= tsevg_pkg::WORD_RST;
    end else if (wr_en && addr == tsevg_pkg::CTRL_OFFSET) begin
      ctrl_r <= wdata;
    end
  end
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      reload_r <= tsevg_pkg::ARVAL_RST[CW-1:0];
    end else if (wr_en && addr == tsevg_pkg::ARVAL_OFFSET) begin
      reload_r <= wdata[CW-1:0];
    end
  end
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      psc_r <= '0;
    end else if (wr_en && addr == tsevg_pkg::PSC_OFFSET) begin
      psc_r <= wdata[CW-1:0];
    end
  end
  // ----------------------------------------------------------------
  // Channels
  // ----------------------------------------------------------------
  // four identical channels
  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_chan
      tsevg_chan #(
        .CW(CW)
      ) u_chan (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .sw_req(chan_req_r[g]),
        .input_mode(ctrl_r[tsevg_pkg::INPUT_LO + g]),
        .flag_clr(flags_wr && !wdata[tsevg_pkg::CC_FLAG_LO + g]),
        .ovc_clr(flags_wr && !wdata[tsevg_pkg::OVC_FLAG_LO + g]),
        .cap_rd(rd_en && addr == tsevg_pkg::CAP0_OFFSET + 8'(4 * g)),
        .counter(count),
        .capcomp_flag_r(cc_flag[g]),
        .overcapture_flag_r(ovc_flag[g]),
        .capture_value_r(cap_val[g])
      );
    end
  endgenerate
  // ----------------------------------------------------------------
  // Counter
  // ----------------------------------------------------------------
  tsevg_cnt #(
    .CW(CW)
  ) u_cnt (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .enable(ctrl_r[tsevg_pkg::CNT_EN_BIT]),
    .down(ctrl_r[tsevg_pkg::DOWN_BIT]),
    .center(|ctrl_r[tsevg_pkg::CENTER_LO +: 2]),
    .upd_req(update_req_r),
    .psc_val(psc_r),
    .reload(reload_r),
    .count_r(count),
    .psc_cnt_r(psc_cnt)
  );
  // ----------------------------------------------------------------
  // Update flag and requests out
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      upd_flag_r <= 1'b0;
    end else if (update_req_r) begin
      upd_flag_r <= 1'b1;
    end else if (flags_wr && !wdata[tsevg_pkg::UPD_FLAG_BIT]) begin
      upd_flag_r <= 1'b0;
    end
  end
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      irq_req_r <= '0;
      dma_req_r <= '0;
      update_irq_r <= 1'b0;
    end else begin
      irq_req_r <= cc_flag & ctrl_r[tsevg_pkg::IEN_LO +: N];
      dma_req_r <= chan_req_r & ctrl_r[tsevg_pkg::DEN_LO +: N];
      update_irq_r <= upd_flag_r;
    end
  end
  // ----------------------------------------------------------------
  // Read back
  // ----------------------------------------------------------------
  always_comb begin
    rdata_nxt = '0;
    case (addr)
      tsevg_pkg::CTRL_OFFSET: rdata_nxt = ctrl_r;
      tsevg_pkg::EVGEN_OFFSET: rdata_nxt = '0;
      tsevg_pkg::FLAGS_OFFSET: begin
        rdata_nxt[tsevg_pkg::UPD_FLAG_BIT] = upd_flag_r;
        rdata_nxt[tsevg_pkg::CC_FLAG_LO +: N] = cc_flag;
        rdata_nxt[tsevg_pkg::OVC_FLAG_LO +: N] = ovc_flag;
      end
      tsevg_pkg::STATE_OFFSET: rdata_nxt[CW-1:0] = count;
      tsevg_pkg::PSC_OFFSET: rdata_nxt[CW-1:0] = psc_r;
      tsevg_pkg::ARVAL_OFFSET: rdata_nxt[CW-1:0] = reload_r;
      tsevg_pkg::CAP0_OFFSET: rdata_nxt[CW-1:0] = cap_val[0];
      tsevg_pkg::CAP0_OFFSET + 8'h04: rdata_nxt[CW-1:0] = cap_val[1];
      tsevg_pkg::CAP0_OFFSET + 8'h08: rdata_nxt[CW-1:0] = cap_val[2];
      tsevg_pkg::CAP0_OFFSET + 8'h0c: rdata_nxt[CW-1:0] = cap_val[3];
      default: rdata_nxt = '0;
    endcase
  end
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      rdata_r <= '0;
    end else if (rd_en) begin
      rdata_r <= rdata_nxt;
    end else begin
      rdata_r <= '0;
    end
  end
endmodule

/* File: tb/tsevg_monitor.sv */
// Port checker for the timer software event generator.
// Assumes it is bound to tsevg_top and sees only its ports.
`timescale 1ns/10ps
module tsevg_monitor #(
  parameter int CW = 16
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [31:0] rdata_r,
  input wire logic [3:0] irq_req_r,
  input wire logic [3:0] dma_req_r,
  input wire logic update_irq_r
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence ev_wr(int b);
    wr_en && addr == tsevg_pkg::EVGEN_OFFSET && wdata[b];
  endsequence
  chk_rdata_idle: assert property (!$past(rd_en) |-> rdata_r == 32'h0)
    else $error("read data seen without a read");
  chk_evgen_rdzero: assert property (rd_en && addr == tsevg_pkg::EVGEN_OFFSET |=>
    rdata_r == 32'h0) else $error("event register read not zero");
  chk_unmapped_zero: assert property (rd_en && addr == 8'h80 |=> rdata_r == 32'h0)
    else $error("unmapped read not zero");
  chk_upd_flag: assert property (ev_wr(0) |-> ##[1:3] update_irq_r)
    else $error("update request did not set update flag");
  chk_upd_hold: assert property (update_irq_r && !wr_en && !$past(wr_en) |=> update_irq_r)
    else $error("update flag dropped without a write");
  for (genvar i = 0; i < 4; i++) begin : g_ch
    chk_irq_cause: assert property ($rose(irq_req_r[i]) |-> $past(wr_en, 2) || $past(wr_en, 3))
      else $error("channel irq rose without a write");
    chk_dma_cause: assert property ($rose(dma_req_r[i]) |->
      $past(wr_en && addr == tsevg_pkg::EVGEN_OFFSET && wdata[i + 1], 2))
      else $error("channel dma rose without its request");
    chk_dma_pulse: assert property (dma_req_r[i] |=> !dma_req_r[i])
      else $error("channel dma longer than one cycle");
  end
endmodule
bind tsevg_top tsevg_monitor #(.CW(CW)) u_mon (.sys_clk(sys_clk), .rstn(rstn), .addr(addr),
  .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata_r(rdata_r), .irq_req_r(irq_req_r),
  .dma_req_r(dma_req_r), .update_irq_r(update_irq_r));

/* File: tb/timer_software_event_generator_tb_top.sv */
// Testbench for the timer software event generator.
// Assumes the register map of tsevg_pkg and a 50 MHz clock.
`timescale 1ns/10ps
module timer_software_event_generator_tb_top;
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic [31:0] rdata_r;
  logic [3:0] irq_req_r;
  logic [3:0] dma_req_r;
  logic update_irq_r;
  int err_count = 0;
  int num_checks = 0;
  tsevg_top DUT (.sys_clk(sys_clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr_en(wr_en),
    .rd_en(rd_en), .rdata_r(rdata_r), .irq_req_r(irq_req_r), .dma_req_r(dma_req_r),
    .update_irq_r(update_irq_r));
  always #10 sys_clk = ~sys_clk;
  // ----------------------------------------------------------------
  // Access tasks
  // ----------------------------------------------------------------
  task chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge sys_clk);
    wr_en <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge sys_clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge sys_clk);
    rd_en <= 1'b0;
    #1 chk($sformatf("read %h", a), rdata_r, exp);
  endtask
  task final_report;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    repeat (2) @(posedge sys_clk);
    rstn <= 1'b1;
    rd(tsevg_pkg::EVGEN_OFFSET, 32'h0);
    rd(tsevg_pkg::ARVAL_OFFSET, 32'h0000ffff);
    rd(8'h80, 32'h0);
    $display("test reset done");
    for (int m = 0; m < 2; m++) begin
      wr(tsevg_pkg::FLAGS_OFFSET, 32'h0);
      wr(tsevg_pkg::CTRL_OFFSET, 32'h00010000 | (m << 1));
      repeat (5) @(posedge sys_clk);
      wr(tsevg_pkg::EVGEN_OFFSET, 32'h1);
      rd(tsevg_pkg::STATE_OFFSET, 32'h0);
      chk("update flag", update_irq_r, 1'b1);
      rd(tsevg_pkg::EVGEN_OFFSET, 32'h0);
    end
    $display("test up and center update done");
    wr(tsevg_pkg::ARVAL_OFFSET, 32'h1234);
    wr(tsevg_pkg::PSC_OFFSET, 32'h7);
    wr(tsevg_pkg::CTRL_OFFSET, 32'h00010001);
    repeat (20) @(posedge sys_clk);
    wr(tsevg_pkg::EVGEN_OFFSET, 32'h1);
    for (int k = 0; k < 3; k++) rd(tsevg_pkg::STATE_OFFSET, 32'h1234);
    wr(tsevg_pkg::CTRL_OFFSET, 32'h1);
    wr(tsevg_pkg::ARVAL_OFFSET, 32'h0abc);
    wr(tsevg_pkg::EVGEN_OFFSET, 32'h1);
    rd(tsevg_pkg::STATE_OFFSET, 32'h00000abc);
    $display("test down update done");
    for (int i = 0; i < 4; i++) begin
      wr(tsevg_pkg::FLAGS_OFFSET, 32'h0);
      wr(tsevg_pkg::CTRL_OFFSET, 32'h1 | (32'h1111 << (4 + i)) & 32'hfff0 | 32'h1);
      wr(tsevg_pkg::EVGEN_OFFSET, 32'h2 << i);
      @(posedge sys_clk);
      #1 chk("dma", dma_req_r, 32'h1 << i);
      @(posedge sys_clk);
      #1 chk("dma end", dma_req_r, 32'h0);
      @(posedge sys_clk);
      #1 chk("irq", irq_req_r, 32'h1 << i);
      wr(tsevg_pkg::EVGEN_OFFSET, 32'h2 << i);
      rd(tsevg_pkg::FLAGS_OFFSET, (32'h2 << i) | (32'h200 << i));
      rd(tsevg_pkg::CAP0_OFFSET + 8'(4 * i), 32'h00000abc);
      rd(tsevg_pkg::FLAGS_OFFSET, 32'h200 << i);
    end
    $display("test channels done");
    wr(tsevg_pkg::FLAGS_OFFSET, 32'h0);
    wr(tsevg_pkg::EVGEN_OFFSET, 32'h0);
    rd(tsevg_pkg::FLAGS_OFFSET, 32'h0);
    $display("test zero write done");
    final_report;
  end
  initial begin
    repeat (5000) @(posedge sys_clk);
    err_count++;
    final_report;
  end
endmodule
